// [verilog/phy_regs_pkg.sv]
// Constants for the transceiver vendor management register bank
// Overview of operation
// - Reg16 bit8 sets pin 1 direction, resets one
// - Reg16 bit9 reads or drives pin 1
// - Reg16 bit7 reads or drives pin 0
// - Reg16 bit6 sets pin 0 direction, resets one
// - Reg16 bit5 disables auto-polarity, resets zero
// - Auto-polarity on: status shows reversed polarity
// - Auto-polarity off: written one inverts transmitter
// - Reversed: eight inverted NLPs or inverted FLP
// - Reg16 bit0 gates receive clock when idle
// - Clock restarts before RX_DV, stops 64 after
// - Loopback or bypass keeps receive clock running
// - Reg17 bits 15..8 are read-write enables
// - Bit7 jabber flag; flags clear on read
// - Bit6 set on receive error rising edge
// - Bit5 set on new page received
// - Bit4 set on parallel detection fault
// - Bit3 set on acknowledged FLP burst
// - Bit1 set on remote fault
// - Bit0 set on negotiation complete
// - Reg16 bit14 selects interrupt output polarity
// - Reg18 bit11 reports negotiated full duplex
// - Reg18 bit10 reports 100 Mbps speed
// - Reg18 bit9 reports valid signal detected
// - Reg18 bit8 PLL lock, held until read
package phy_regs_pkg;
    localparam logic [4:0] MISC_ADDR = 5'h10;
    localparam logic [4:0] IRQ_ADDR  = 5'h11;
    localparam logic [4:0] DIAG_ADDR = 5'h12;
    localparam int IRQ_POL_BIT  = 14;
    localparam int GP1_DATA_BIT = 9;
    localparam int GP1_DIR_BIT  = 8;
    localparam int GP0_DATA_BIT = 7;
    localparam int GP0_DIR_BIT  = 6;
    localparam int APOL_DIS_BIT = 5;
    localparam int POL_BIT      = 4;
    localparam int RXCG_BIT     = 0;
    localparam int EN_LSB       = 8;
    localparam int NEGOTIATED_FULL_DUPLEX_BIT     = 11;
    localparam int SPEED_BIT    = 10;
    localparam int PASS_BIT     = 9;
    localparam int LOCK_BIT     = 8;
    localparam int NLP_INV_COUNT = 8;
    localparam int RXCLK_HOLD    = 64;
endpackage

// [verilog/phy_misc_irq_diag_regs.sv]
// Vendor management registers: GPIO, polarity, receive clock gate, events, diagnostics
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module phy_misc_irq_diag_regs (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // Register port
    input  wire logic [4:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // General purpose pins
    input  wire logic [1:0]  GPIO_IN,
    output logic      [1:0]  GPIO_OUT,
    output logic      [1:0]  GPIO_OE,
    // Polarity
    input  wire logic        NLP_SEEN,
    input  wire logic        NLP_INVERTED,
    input  wire logic        FLP_INVERTED,
    output logic             TX_POL_INVERT,
    // Receive clock gate
    input  wire logic        LINK_UP,
    input  wire logic        LOOPBACK,
    input  wire logic        PCS_BYPASS,
    input  wire logic        RX_DV_NEXT,
    output logic             RX_CLK_EN,
    // Events, same clock domain
    input  wire logic        JABBER_EV,
    input  wire logic        RX_ER,
    input  wire logic        PAGE_EV,
    input  wire logic        PD_FAULT_EV,
    input  wire logic        ACK_FLP_EV,
    input  wire logic        REMOTE_FAULT_EV,
    input  wire logic        ANEG_DONE_EV,
    // Diagnostics
    input  wire logic        FULL_DUPLEX,
    input  wire logic        SPEED_100,
    input  wire logic        SIGNAL_PASS,
    input  wire logic        PLL_LOCKED,
    // Interrupt
    output logic             IRQ_OUTPUT
);
    // Register state
    logic [1:0] gp_dir, gp_data, gp_s1, gp_s2;
    logic       irq_polarity_select, apol_dis, pol_stat, tx_inv, rxcg;
    logic [7:0] event_en, event_flag;
    logic       lock_hold, rx_er_d, link_d;
    logic [3:0] nlp_cnt;
    logic [6:0] hold_cnt;
    logic [1:0] next_gp_dir, next_gp_data;
    logic       next_irq_pol, next_apol_dis, next_pol_stat, next_tx_inv, next_rxcg;
    logic [7:0] next_en, next_flag, ev;
    logic       next_lock, next_rxen, rx_en, next_irq;
    logic [3:0] next_nlp;
    logic [6:0] next_hold;
    logic [15:0] rd_word, next_rdata;
    logic       wr_misc, wr_irq, rd_irq, rd_diag;

    assign wr_misc = WR && ADDR == phy_regs_pkg::MISC_ADDR;
    assign wr_irq  = WR && ADDR == phy_regs_pkg::IRQ_ADDR;
    assign rd_irq  = RD && ADDR == phy_regs_pkg::IRQ_ADDR;
    assign rd_diag = RD && ADDR == phy_regs_pkg::DIAG_ADDR;

    // Event vector, bit 7 jabber down to bit 0 negotiation complete
    always_comb begin
        ev[7] = JABBER_EV;
        ev[6] = RX_ER && !rx_er_d;
        ev[5] = PAGE_EV;
        ev[4] = PD_FAULT_EV;
        ev[3] = ACK_FLP_EV;
        ev[2] = link_d && !LINK_UP;
        ev[1] = REMOTE_FAULT_EV;
        ev[0] = ANEG_DONE_EV;
    end

    always_comb begin
        rd_word = 16'h0000;
        case (ADDR)
            phy_regs_pkg::MISC_ADDR: begin
                rd_word[phy_regs_pkg::IRQ_POL_BIT]  = irq_polarity_select;
                rd_word[phy_regs_pkg::GP1_DATA_BIT] = gp_dir[1] ? gp_s2[1] : gp_data[1];
                rd_word[phy_regs_pkg::GP1_DIR_BIT]  = gp_dir[1];
                rd_word[phy_regs_pkg::GP0_DATA_BIT] = gp_dir[0] ? gp_s2[0] : gp_data[0];
                rd_word[phy_regs_pkg::GP0_DIR_BIT]  = gp_dir[0];
                rd_word[phy_regs_pkg::APOL_DIS_BIT] = apol_dis;
                rd_word[phy_regs_pkg::POL_BIT]      = apol_dis ? tx_inv : pol_stat;
                rd_word[phy_regs_pkg::RXCG_BIT]     = rxcg;
            end
            phy_regs_pkg::IRQ_ADDR: rd_word = {event_en, event_flag};
            phy_regs_pkg::DIAG_ADDR: begin
                rd_word[phy_regs_pkg::NEGOTIATED_FULL_DUPLEX_BIT]  = FULL_DUPLEX;
                rd_word[phy_regs_pkg::SPEED_BIT] = SPEED_100;
                rd_word[phy_regs_pkg::PASS_BIT]  = SIGNAL_PASS;
                rd_word[phy_regs_pkg::LOCK_BIT]  = lock_hold;
            end
            default: rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        next_gp_dir   = gp_dir;
        next_gp_data  = gp_data;
        next_irq_pol  = irq_polarity_select;
        next_apol_dis = apol_dis;
        next_tx_inv   = tx_inv;
        next_rxcg     = rxcg;
        next_en       = event_en;
        next_rdata    = RD ? rd_word : 16'h0000;
        if (wr_misc) begin
            next_irq_pol  = WDATA[phy_regs_pkg::IRQ_POL_BIT];
            next_gp_dir   = {WDATA[phy_regs_pkg::GP1_DIR_BIT], WDATA[phy_regs_pkg::GP0_DIR_BIT]};
            next_gp_data  = {WDATA[phy_regs_pkg::GP1_DATA_BIT], WDATA[phy_regs_pkg::GP0_DATA_BIT]};
            next_apol_dis = WDATA[phy_regs_pkg::APOL_DIS_BIT];
            next_rxcg     = WDATA[phy_regs_pkg::RXCG_BIT];
            if (WDATA[phy_regs_pkg::APOL_DIS_BIT] || apol_dis)
                next_tx_inv = WDATA[phy_regs_pkg::POL_BIT];
        end
        if (wr_irq)
            next_en = WDATA[15:phy_regs_pkg::EN_LSB];
        // Set wins over the read clear
        next_flag = (rd_irq ? 8'h00 : event_flag) | ev;
        next_lock = (rd_diag ? 1'b0 : lock_hold) | PLL_LOCKED;
    end

    // Polarity detector: eight inverted NLPs in a row or one inverted FLP burst
    always_comb begin
        next_nlp      = nlp_cnt;
        next_pol_stat = pol_stat;
        if (NLP_SEEN)
            next_nlp = NLP_INVERTED ? ((nlp_cnt == 4'(phy_regs_pkg::NLP_INV_COUNT))
                                       ? nlp_cnt : nlp_cnt + 4'h1) : 4'h0;
        if (apol_dis)
            next_pol_stat = 1'b0;
        else if (FLP_INVERTED || next_nlp == 4'(phy_regs_pkg::NLP_INV_COUNT))
            next_pol_stat = 1'b1;
        else if (NLP_SEEN && !NLP_INVERTED)
            next_pol_stat = 1'b0;
    end

    // Receive clock gate; RX_DV_NEXT leads RX_DV by one cycle so the clock resumes early
    always_comb begin
        next_hold = hold_cnt;
        if (RX_DV_NEXT)
            next_hold = 7'(phy_regs_pkg::RXCLK_HOLD);
        else if (hold_cnt != 7'h00)
            next_hold = hold_cnt - 7'h01;
        if (LOOPBACK || PCS_BYPASS)
            next_rxen = 1'b1;
        else if (!LINK_UP || !rxcg)
            next_rxen = 1'b1;
        else
            next_rxen = RX_DV_NEXT || hold_cnt != 7'h00;
        next_irq = ((event_flag & event_en) != 8'h00) ~^ irq_polarity_select;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            gp_dir              <= 2'h3;
            gp_data             <= 2'h0;
            gp_s1               <= 2'h0;
            gp_s2               <= 2'h0;
            irq_polarity_select <= 1'b0;
            apol_dis            <= 1'b0;
            pol_stat            <= 1'b0;
            tx_inv              <= 1'b0;
            rxcg                <= 1'b0;
            event_en            <= 8'h00;
            event_flag          <= 8'h00;
            lock_hold           <= 1'b0;
            rx_er_d             <= 1'b0;
            link_d              <= 1'b0;
            nlp_cnt             <= 4'h0;
            hold_cnt            <= 7'h00;
            rx_en               <= 1'b1;
            RDATA               <= 16'h0000;
            IRQ_OUTPUT          <= 1'b1;
        end else begin
            gp_dir              <= next_gp_dir;
            gp_data             <= next_gp_data;
            gp_s1               <= GPIO_IN;
            gp_s2               <= gp_s1;
            irq_polarity_select <= next_irq_pol;
            apol_dis            <= next_apol_dis;
            pol_stat            <= next_pol_stat;
            tx_inv              <= next_tx_inv;
            rxcg                <= next_rxcg;
            event_en            <= next_en;
            event_flag          <= next_flag;
            lock_hold           <= next_lock;
            rx_er_d             <= RX_ER;
            link_d              <= LINK_UP;
            nlp_cnt             <= next_nlp;
            hold_cnt            <= next_hold;
            rx_en               <= next_rxen;
            RDATA               <= next_rdata;
            IRQ_OUTPUT          <= next_irq;
        end
    end

    // Registered data and enables for the pins
    assign GPIO_OUT      = gp_data;
    assign GPIO_OE       = ~gp_dir;
    assign TX_POL_INVERT = apol_dis & tx_inv;
    assign RX_CLK_EN     = rx_en;

    flag_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_irq && ev == 8'h00 |=> event_flag == 8'h00)
        else $error("event flags not cleared by read");

    rxer_edge_a: assert property (@(posedge CLK) disable iff (SRST)
        RX_ER && !rx_er_d |=> event_flag[6])
        else $error("receive error edge lost");

    link_loss_a: assert property (@(posedge CLK) disable iff (SRST)
        $fell(LINK_UP) |=> event_flag[2])
        else $error("link loss flag missing");

    irq_level_a: assert property (@(posedge CLK) disable iff (SRST)
        (event_flag & event_en) != 8'h00 |=> IRQ_OUTPUT == irq_polarity_select)
        else $error("interrupt not asserted");

    loop_clock_a: assert property (@(posedge CLK) disable iff (SRST)
        LOOPBACK |=> RX_CLK_EN)
        else $error("receive clock gated in loopback");

    gate_stop_a: assert property (@(posedge CLK) disable iff (SRST)
        rxcg && LINK_UP && !LOOPBACK && !PCS_BYPASS && hold_cnt == 7'h00
        && !RX_DV_NEXT |=> !RX_CLK_EN)
        else $error("receive clock not gated");

    dv_start_a: assert property (@(posedge CLK) disable iff (SRST)
        RX_DV_NEXT |=> RX_CLK_EN)
        else $error("receive clock late before data");

    lock_hold_a: assert property (@(posedge CLK) disable iff (SRST)
        PLL_LOCKED ##1 !rd_diag |=> lock_hold)
        else $error("lock indication dropped before read");

    flp_pol_a: assert property (@(posedge CLK) disable iff (SRST)
        FLP_INVERTED && !apol_dis |=> pol_stat)
        else $error("inverted burst not reported");

    gpio_dir_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_misc |=> GPIO_OE[0] == !$past(WDATA[phy_regs_pkg::GP0_DIR_BIT]))
        else $error("pin 0 direction not applied");

    gp1_dir_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_misc |=> GPIO_OE[1] == !$past(WDATA[phy_regs_pkg::GP1_DIR_BIT]))
        else $error("pin 1 direction not applied");

    gp_out_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_misc |=> GPIO_OUT == {$past(WDATA[phy_regs_pkg::GP1_DATA_BIT]),
                                 $past(WDATA[phy_regs_pkg::GP0_DATA_BIT])})
        else $error("pin output data not applied");

    gp1_read_a: assert property (@(posedge CLK) disable iff (SRST)
        RD && ADDR == phy_regs_pkg::MISC_ADDR && gp_dir[1]
        |=> RDATA[phy_regs_pkg::GP1_DATA_BIT] == $past(gp_s2[1]))
        else $error("pin 1 level not returned");

    gp0_read_a: assert property (@(posedge CLK) disable iff (SRST)
        RD && ADDR == phy_regs_pkg::MISC_ADDR && gp_dir[0]
        |=> RDATA[phy_regs_pkg::GP0_DATA_BIT] == $past(gp_s2[0]))
        else $error("pin 0 level not returned");

    apol_write_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_misc |=> apol_dis == $past(WDATA[phy_regs_pkg::APOL_DIS_BIT]))
        else $error("auto-polarity disable not stored");

    apol_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        apol_dis |=> !pol_stat)
        else $error("polarity status set while disabled");

    nlp_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        !apol_dis && NLP_SEEN && !NLP_INVERTED && !FLP_INVERTED |=> !pol_stat)
        else $error("normal pulse did not clear polarity");

    nlp_count_a: assert property (@(posedge CLK) disable iff (SRST)
        !apol_dis && NLP_SEEN && NLP_INVERTED
        && nlp_cnt == 4'(phy_regs_pkg::NLP_INV_COUNT - 1) |=> pol_stat)
        else $error("inverted pulse run not reported");

    tx_auto_a: assert property (@(posedge CLK) disable iff (SRST)
        !apol_dis |-> !TX_POL_INVERT)
        else $error("transmitter inverted under auto-polarity");

    tx_write_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_misc && WDATA[phy_regs_pkg::APOL_DIS_BIT]
        |=> TX_POL_INVERT == $past(WDATA[phy_regs_pkg::POL_BIT]))
        else $error("transmitter inversion not applied");

    bypass_clock_a: assert property (@(posedge CLK) disable iff (SRST)
        PCS_BYPASS |=> RX_CLK_EN)
        else $error("receive clock gated in bypass");

    gate_off_a: assert property (@(posedge CLK) disable iff (SRST)
        !rxcg |=> RX_CLK_EN)
        else $error("receive clock gated while gating off");

    nolink_clock_a: assert property (@(posedge CLK) disable iff (SRST)
        !LINK_UP |=> RX_CLK_EN)
        else $error("receive clock gated without link");

    hold_load_a: assert property (@(posedge CLK) disable iff (SRST)
        RX_DV_NEXT |=> hold_cnt == 7'(phy_regs_pkg::RXCLK_HOLD))
        else $error("hold counter not reloaded");

    hold_count_a: assert property (@(posedge CLK) disable iff (SRST)
        !RX_DV_NEXT && hold_cnt != 7'h00 |=> hold_cnt == $past(hold_cnt) - 7'h01)
        else $error("hold counter not counting down");

    hold_run_a: assert property (@(posedge CLK) disable iff (SRST)
        hold_cnt != 7'h00 |=> RX_CLK_EN)
        else $error("receive clock stopped during hold");

    jabber_set_a: assert property (@(posedge CLK) disable iff (SRST)
        JABBER_EV |=> event_flag[7])
        else $error("jabber flag missing");

    page_set_a: assert property (@(posedge CLK) disable iff (SRST)
        PAGE_EV |=> event_flag[5])
        else $error("page flag missing");

    pd_set_a: assert property (@(posedge CLK) disable iff (SRST)
        PD_FAULT_EV |=> event_flag[4])
        else $error("parallel fault flag missing");

    ack_set_a: assert property (@(posedge CLK) disable iff (SRST)
        ACK_FLP_EV |=> event_flag[3])
        else $error("partner acknowledge flag missing");

    remote_set_a: assert property (@(posedge CLK) disable iff (SRST)
        REMOTE_FAULT_EV |=> event_flag[1])
        else $error("remote fault flag missing");

    aneg_set_a: assert property (@(posedge CLK) disable iff (SRST)
        ANEG_DONE_EV |=> event_flag[0])
        else $error("negotiation done flag missing");

    flag_sticky_a: assert property (@(posedge CLK) disable iff (SRST)
        !rd_irq |=> (event_flag & $past(event_flag)) == $past(event_flag))
        else $error("event flag lost without read");

    flag_read_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_irq |=> RDATA == {$past(event_en), $past(event_flag)})
        else $error("event register read wrong");

    enable_write_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_irq |=> event_en == $past(WDATA[15:phy_regs_pkg::EN_LSB]))
        else $error("event enables not stored");

    enable_hold_a: assert property (@(posedge CLK) disable iff (SRST)
        !wr_irq |=> $stable(event_en))
        else $error("event enables changed without write");

    irq_idle_a: assert property (@(posedge CLK) disable iff (SRST)
        (event_flag & event_en) == 8'h00 && !wr_misc
        |=> IRQ_OUTPUT != irq_polarity_select)
        else $error("interrupt active with no enabled flag");

    irq_pol_a: assert property (@(posedge CLK) disable iff (SRST)
        wr_misc |=> irq_polarity_select == $past(WDATA[phy_regs_pkg::IRQ_POL_BIT]))
        else $error("interrupt polarity not stored");

    duplex_read_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_diag |=> RDATA[phy_regs_pkg::NEGOTIATED_FULL_DUPLEX_BIT] == $past(FULL_DUPLEX))
        else $error("duplex read wrong");

    speed_read_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_diag |=> RDATA[phy_regs_pkg::SPEED_BIT] == $past(SPEED_100))
        else $error("speed read wrong");

    pass_read_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_diag |=> RDATA[phy_regs_pkg::PASS_BIT] == $past(SIGNAL_PASS))
        else $error("signal detect read wrong");

    lock_read_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_diag |=> RDATA[phy_regs_pkg::LOCK_BIT] == $past(lock_hold))
        else $error("lock read wrong");

    lock_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        rd_diag && !PLL_LOCKED |=> !lock_hold)
        else $error("lock not cleared by read");
endmodule
`default_nettype wire

// [bench/mgmt_master.sv]
// Station management master model for the register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_master (
    // Register port
    input  wire logic        clk,
    output logic      [4:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    initial begin
        addr = 5'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic read(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the vendor management register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        CLK, SRST, nlp, ninv, finv, dvn, lpbk, fd, s100, pass, lock, byp;
    logic [1:0]  gin;
    logic [7:0]  ev, en;
    logic [4:0]  a;
    logic [15:0] wd, rd_data, rv;
    logic        wr, rd, irq, txinv, ckEn;
    logic [1:0]  gout, goe;
    int          err_total, compares, n;
    phy_misc_irq_diag_regs DUT (.CLK(CLK), .SRST(SRST), .ADDR(a), .WDATA(wd), .WR(wr),
        .RD(rd), .RDATA(rd_data), .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe),
        .NLP_SEEN(nlp), .NLP_INVERTED(ninv), .FLP_INVERTED(finv), .TX_POL_INVERT(txinv),
        .LINK_UP(~ev[2]), .LOOPBACK(lpbk), .PCS_BYPASS(byp), .RX_DV_NEXT(dvn),
        .RX_CLK_EN(ckEn), .JABBER_EV(ev[7]), .RX_ER(ev[6]), .PAGE_EV(ev[5]),
        .PD_FAULT_EV(ev[4]), .ACK_FLP_EV(ev[3]), .REMOTE_FAULT_EV(ev[1]),
        .ANEG_DONE_EV(ev[0]), .FULL_DUPLEX(fd), .SPEED_100(s100), .SIGNAL_PASS(pass),
        .PLL_LOCKED(lock), .IRQ_OUTPUT(irq));
    mgmt_master m (.clk(CLK), .addr(a), .wdata(wd), .wr(wr), .rd(rd), .rdata(rd_data));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] adr, input logic [15:0] exp);
        m.read(adr, rv);
        chk(rv, exp);
    endtask
    // Misc word as software should see it with both pins as inputs
    function automatic logic [15:0] misc(input logic [1:0] p, input logic pol);
        return 16'h0140 | (16'(p[1]) << 9) | (16'(p[0]) << 7) | (16'(pol) << 4);
    endfunction
    task automatic nlp_pulse(input logic inv);
        @(posedge CLK);
        nlp <= 1'b1;
        ninv <= inv;
        @(posedge CLK);
        nlp <= 1'b0;
    endtask
    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
    initial begin
        {nlp, ninv, finv, dvn, lpbk, fd, s100, pass, lock, byp} = '0;
        gin = 2'b00;
        ev = 8'h00;
        SRST = 1'b1;
        void'($urandom(32'hed3fda39));
        repeat (3) @(posedge CLK);
        SRST <= 1'b0;
        chk(16'({goe, irq, ckEn}), 16'h3);
        rchk(5'h10, 16'h0140);
        rchk(5'h11, 16'h0000);
        rchk(5'h12, 16'h0000);
        rchk(5'h1f, 16'h0000);
        $display("test reset done");
        n = $urandom;
        m.write(5'h10, 16'h0 | (16'(n[1]) << 9) | (16'(n[0]) << 7));
        #1;
        chk(16'({goe, gout}), {12'h0, 2'b11, n[1:0]});
        m.write(5'h10, 16'h0140);
        gin <= n[3:2];
        repeat (3) @(posedge CLK);
        chk(16'(goe), 16'h0);
        rchk(5'h10, misc(n[3:2], 1'b0));
        gin <= 2'b00;
        $display("test gpio done");
        m.write(5'h10, 16'h4140);
        for (int i = 0; i < 8; i++) begin
            en = $urandom;
            m.write(5'h11, {en, 8'h00});
            @(posedge CLK);
            ev <= 8'h01 << i;
            @(posedge CLK);
            ev <= 8'h00;
            repeat (2) @(posedge CLK);
            #1;
            chk(16'(irq), 16'(en[i]));
            rchk(5'h11, {en, 8'h01 << i});
            rchk(5'h11, {en, 8'h00});
        end
        m.write(5'h10, 16'h0140);
        repeat (2) @(posedge CLK);
        chk(16'(irq), 16'h1);
        m.write(5'h11, 16'hff00);
        @(posedge CLK);
        ev <= 8'h80;
        @(posedge CLK);
        ev <= 8'h00;
        repeat (2) @(posedge CLK);
        #1;
        chk(16'(irq), 16'h0);
        rchk(5'h11, 16'hff80);
        m.write(5'h11, 16'h0000);
        $display("test events done");
        for (int k = 7; k <= 8; k++) begin
            nlp_pulse(1'b0);
            for (int j = 0; j < k; j++)
                nlp_pulse(1'b1);
            rchk(5'h10, misc(2'b00, k == 8));
        end
        nlp_pulse(1'b0);
        rchk(5'h10, misc(2'b00, 1'b0));
        @(posedge CLK);
        finv <= 1'b1;
        @(posedge CLK);
        finv <= 1'b0;
        rchk(5'h10, misc(2'b00, 1'b1));
        m.write(5'h10, 16'h0170);
        @(posedge CLK);
        chk(16'(txinv), 16'h1);
        m.write(5'h10, 16'h0141);
        $display("test polarity done");
        @(posedge CLK);
        dvn <= 1'b1;
        repeat (5) @(posedge CLK);
        dvn <= 1'b0;
        n = 0;
        for (int c = 0; c < 100; c++) begin
            @(posedge CLK);
            #1;
            if (ckEn === 1'b1)
                n++;
        end
        chk(16'(n >= 63 && n <= 66), 16'h1);
        dvn <= 1'b1;
        @(posedge CLK);
        #1;
        chk(16'(ckEn), 16'h1);
        dvn <= 1'b0;
        lpbk <= 1'b1;
        repeat (80) @(posedge CLK);
        chk(16'(ckEn), 16'h1);
        lpbk <= 1'b0;
        byp <= 1'b1;
        repeat (80) @(posedge CLK);
        chk(16'(ckEn), 16'h1);
        byp <= 1'b0;
        m.write(5'h10, 16'h0140);
        repeat (80) @(posedge CLK);
        chk(16'(ckEn), 16'h1);
        $display("test clock gate done");
        n = $urandom;
        fd <= n[2];
        s100 <= n[1];
        pass <= n[0];
        lock <= 1'b1;
        @(posedge CLK);
        lock <= 1'b0;
        m.write(5'h12, 16'hffff);
        rchk(5'h12, {4'h0, n[2:0], 1'b1, 8'h00});
        rchk(5'h12, {4'h0, n[2:0], 1'b0, 8'h00});
        @(posedge CLK);
        #1;
        chk(rd_data, 16'h0000);
        $display("test diagnostics done");
        complete_run();
    end
endmodule
`default_nettype wire
